// ---- usah_pkg.sv ----
// Purpose: Shared constants and types for the SPI host and async receiver.
// Assumes: One 50 MHz core clock, synchronous active-high reset.
// Notes: Fractional baud generation lives outside; a reload divider is used.

package usah_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int USAH_CLK_HZ = 50_000_000;
    localparam logic [15:0] USAH_DIV_RST = 16'h0000;

    // ------------------------------------------------------------
    // Receive mode field and oversampling
    // ------------------------------------------------------------
    localparam logic [1:0] USAH_RECEIVE_MODE_SELECT_NORMAL = 2'h0;
    localparam logic [1:0] USAH_RECEIVE_MODE_SELECT_DOUBLE = 2'h1;
    localparam logic [4:0] USAH_OSR_NORMAL = 5'h10;
    localparam logic [4:0] USAH_OSR_DOUBLE = 5'h08;
    localparam logic [4:0] USAH_VOTE_FIRST_NORMAL = 5'h08;
    localparam logic [4:0] USAH_VOTE_FIRST_DOUBLE = 5'h04;
    localparam logic [4:0] USAH_VOTE_SPAN = 5'h02;
    localparam logic [4:0] USAH_SAMPLE_FIRST = 5'h01;

    // ------------------------------------------------------------
    // Frame sizes
    // ------------------------------------------------------------
    localparam logic [3:0] USAH_CHAR_MAX = 4'h8;
    localparam logic [3:0] USAH_SPI_EDGE_LAST = 4'hf;
    localparam logic [1:0] USAH_HIST_RST = 2'h3;

    // ------------------------------------------------------------
    // Carriers and states
    // ------------------------------------------------------------
    typedef struct packed {
        logic spi_host;
        logic [1:0] receive_mode_select;
        logic pin_invert_enable;
        logic spi_clock_phase;
        logic data_order_select;
        logic [3:0] char_bits;
        logic parity_enable;
        logic parity_odd;
    } usah_cfg_s;

    typedef struct packed {
        logic [7:0] data;
        logic frame_error_flag;
        logic parity_error_flag;
        logic overflow_flag;
    } usah_rx_s;

    typedef enum logic [2:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_PARITY,
        RX_STOP
    } usah_rxst_e;

    typedef enum logic {
        SPI_IDLE,
        SPI_SHIFT
    } usah_spist_e;

endpackage

// ---- usah_vote.sv ----
// Purpose: Three-sample majority voter over the oversampled line.
// Assumes: samp_en is a one-cycle pulse on core_clk.
// Notes: maj covers the two previous samples and the current level.

`timescale 1ns/1ns

module usah_vote
    import usah_pkg::*;
(
    input wire logic core_clk, // Core clock
    input wire logic rst, // Sync reset
    input wire logic samp_en, // Sample strobe
    input wire logic lvl, // Filtered line level
    output logic maj // Majority of three samples
);

    logic [1:0] hist_reg;
    logic [1:0] hist_next;

    always_comb begin
        hist_next = samp_en ? {hist_reg[0], lvl} : hist_reg;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            hist_reg <= USAH_HIST_RST;
        end else begin
            hist_reg <= hist_next;
        end
    end

    assign maj = (hist_reg[1] & hist_reg[0]) | (hist_reg[1] & lvl) |
                 (hist_reg[0] & lvl);

endmodule

// ---- usah_top.sv ----
// Purpose: SPI host shifter and oversampling async receiver with recovery.
// Assumes: baud_div >= 4 so the 3-stage input filter settles per half bit.
// Notes: Async data arrives LSb first; char_bits must be 5..8.

`timescale 1ns/1ns

// How it works
// - As SPI host, drive shift clock from the internal baud divider.
// - Each SPI bit holds a full clock; the far side samples mid-hold.
// - Invert and phase bits choose sample and shift edges per table.
// - Leading edge is the first edge of a bit, trailing the last.
// - SPI transmit flags behave like normal transmission.
// - In SPI host mode frame, overflow and parity flags read zero.
// - No write collision, double-speed SPI clock or multi-host logic.
// - txd is MOSI, rxd is MISO, shift clock is SCK; no select pin.
// - Async receiver realigns its sample counter on each start bit.
// - Oversample sixteen times per bit, eight in double speed.
// - Start detection begins on a high-to-low edge; that sample is one.
// - Start accepted if two of samples 8-10 (4-6) are low, else idle.
// - Data and parity bits decided by majority of three centre samples.
// - Only the first stop bit is examined; later ones are ignored.
// - A low voted stop bit sets the frame error flag.
// - Normal mode accepts a new start right after stop vote samples.
// - Double speed sees the next start no earlier than next sample.
// - Vote window starts at sample 8 (4), middle at 9 (5).
// - Receive mode 0x01 selects double speed, 0x00 normal speed.
// - SPI frames are eight data bits; order bit picks LSb or MSb first.
module usah_top
    import usah_pkg::*;
(
    input wire logic core_clk, // 50 MHz core clock
    input wire logic rst, // Sync reset, active high
    input wire usah_cfg_s cfg, // Mode and format settings
    input wire logic [15:0] baud_div, // Sample period minus one
    input wire logic rxd, // Receive pin, MISO in SPI host
    input wire logic tx_start, // Pulse: start SPI transfer
    input wire logic [7:0] tx_data, // Byte to send
    input wire logic rx_read, // Pulse: receive word consumed
    output logic txd, // Transmit pin, MOSI
    output logic shift_clock_pin, // Shift clock out, SCK
    output logic shift_clock_oe, // Shift clock output enable
    output logic tx_busy, // SPI transfer in progress
    output logic tx_done, // Pulse: SPI transfer complete
    output logic rx_valid, // Pulse: new receive word
    output logic rx_full, // Receive word not yet read
    output usah_rx_s rx_word // Received data and flags
);

    // ------------------------------------------------------------
    // Sample divider and input filter
    // ------------------------------------------------------------
    logic [15:0] div_reg, div_next;
    logic samp_en_reg, samp_en_next;
    logic s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next;
    usah_spist_e spi_state_reg, spi_state_next;

    always_comb begin
        samp_en_next = 1'b0;
        div_next = div_reg - 16'h0001;
        if (div_reg == 16'h0000) begin
            div_next = baud_div;
            samp_en_next = 1'b1;
        end
        // Restart on SPI start so the first bit gets a full half period
        if (cfg.spi_host && tx_start && spi_state_reg == SPI_IDLE) begin
            div_next = baud_div;
            samp_en_next = 1'b0;
        end
        lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            div_reg <= USAH_DIV_RST;
            samp_en_reg <= 1'b0;
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
            lvl_reg <= 1'b1;
        end else begin
            div_reg <= div_next;
            samp_en_reg <= samp_en_next;
            s1_reg <= rxd;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            lvl_reg <= lvl_next;
        end
    end

    // ------------------------------------------------------------
    // SPI host shifter
    // ------------------------------------------------------------
    logic [3:0] edge_reg, edge_next;
    logic [7:0] tx_sh_reg, tx_sh_next, spi_in_reg, spi_in_next;
    logic sck_reg, sck_next, txd_reg, txd_next, oe_reg, oe_next;
    logic busy_reg, busy_next, done_reg, done_next;
    logic spi_fin, msb_first, lead, sample_now;

    always_comb begin
        spi_state_next = spi_state_reg;
        edge_next = edge_reg;
        tx_sh_next = tx_sh_reg;
        spi_in_next = spi_in_reg;
        sck_next = sck_reg;
        txd_next = txd_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        spi_fin = 1'b0;
        oe_next = cfg.spi_host;
        msb_first = ~cfg.data_order_select;
        lead = ~edge_reg[0];
        sample_now = lead ^ cfg.spi_clock_phase;
        unique case (spi_state_reg)
            SPI_IDLE: begin
                sck_next = cfg.pin_invert_enable;
                txd_next = 1'b1;
                busy_next = 1'b0;
                if (cfg.spi_host && tx_start) begin
                    spi_state_next = SPI_SHIFT;
                    edge_next = 4'h0;
                    busy_next = 1'b1;
                    tx_sh_next = tx_data;
                    // Phase 0 must present the first data bit (bit 7 MSb first, bit 0 LSb first) before the first edge
                    if (!cfg.spi_clock_phase) begin
                        txd_next = msb_first ? tx_data[7] : tx_data[0];
                        tx_sh_next = msb_first ? {tx_data[6:0], 1'b0} :
                                                 {1'b0, tx_data[7:1]};
                    end
                end
            end
            SPI_SHIFT: begin
                // Start while busy is simply ignored, no collision flag
                if (!cfg.spi_host) begin
                    spi_state_next = SPI_IDLE;
                    busy_next = 1'b0;
                end else if (samp_en_reg) begin
                    sck_next = ~sck_reg;
                    edge_next = edge_reg + 4'h1;
                    if (sample_now) begin
                        spi_in_next = msb_first ?
                            {spi_in_reg[6:0], lvl_reg} :
                            {lvl_reg, spi_in_reg[7:1]};
                    end else if (edge_reg != USAH_SPI_EDGE_LAST) begin
                        txd_next = msb_first ? tx_sh_reg[7] : tx_sh_reg[0];
                        tx_sh_next = msb_first ? {tx_sh_reg[6:0], 1'b0} :
                                                 {1'b0, tx_sh_reg[7:1]};
                    end
                    if (edge_reg == USAH_SPI_EDGE_LAST) begin
                        spi_state_next = SPI_IDLE;
                        busy_next = 1'b0;
                        done_next = 1'b1;
                        spi_fin = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            spi_state_reg <= SPI_IDLE;
            edge_reg <= 4'h0;
            tx_sh_reg <= 8'h00;
            spi_in_reg <= 8'h00;
            sck_reg <= 1'b0;
            txd_reg <= 1'b1;
            oe_reg <= 1'b0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            spi_state_reg <= spi_state_next;
            edge_reg <= edge_next;
            tx_sh_reg <= tx_sh_next;
            spi_in_reg <= spi_in_next;
            sck_reg <= sck_next;
            txd_reg <= txd_next;
            oe_reg <= oe_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    // ------------------------------------------------------------
    // Async clock and data recovery
    // ------------------------------------------------------------
    usah_rxst_e rx_state_reg, rx_state_next;
    logic [4:0] cnt_reg, cnt_next, osr, vfirst, vlast;
    logic [3:0] bit_reg, bit_next, bit_inc;
    logic [7:0] sh_reg, sh_next;
    logic par_reg, par_next, armed_reg, armed_next, maj;
    logic valid_reg, valid_next, full_reg, full_next;
    usah_rx_s word_reg, word_next;
    logic dbl, vote_now;

    usah_vote usah_vote_inst (
        .core_clk(core_clk),
        .rst(rst),
        .samp_en(samp_en_reg),
        .lvl(lvl_reg),
        .maj(maj)
    );

    always_comb begin
        dbl = (cfg.receive_mode_select == USAH_RECEIVE_MODE_SELECT_DOUBLE);
        osr = dbl ? USAH_OSR_DOUBLE : USAH_OSR_NORMAL;
        vfirst = dbl ? USAH_VOTE_FIRST_DOUBLE : USAH_VOTE_FIRST_NORMAL;
        vlast = vfirst + USAH_VOTE_SPAN;
        vote_now = samp_en_reg && (cnt_reg == vlast) &&
                   (rx_state_reg != RX_IDLE);
        bit_inc = bit_reg + 4'h1;
        rx_state_next = rx_state_reg;
        cnt_next = cnt_reg;
        bit_next = bit_reg;
        sh_next = sh_reg;
        par_next = par_reg;
        armed_next = armed_reg;
        word_next = word_reg;
        valid_next = 1'b0;
        // Set beats clear when a word lands in the read cycle
        full_next = full_reg & ~rx_read;
        if (cfg.spi_host) begin
            rx_state_next = RX_IDLE;
            armed_next = 1'b0;
            // A word held from async mode must not show its flags
            word_next.frame_error_flag = 1'b0;
            word_next.parity_error_flag = 1'b0;
            word_next.overflow_flag = 1'b0;
            if (spi_fin) begin
                word_next = '{data: spi_in_next, frame_error_flag: 1'b0,
                              parity_error_flag: 1'b0,
                              overflow_flag: 1'b0};
                valid_next = 1'b1;
                full_next = 1'b1;
            end
        end else if (samp_en_reg) begin
            if (rx_state_reg == RX_IDLE) begin
                if (lvl_reg) begin
                    armed_next = 1'b1;
                end else if (armed_reg) begin
                    rx_state_next = RX_START;
                    // Counter holds the number of the sample to come
                    cnt_next = USAH_SAMPLE_FIRST + 5'h01;
                    armed_next = 1'b0;
                end
            end else begin
                cnt_next = (cnt_reg == osr) ? USAH_SAMPLE_FIRST :
                                              cnt_reg + 5'h01;
            end
            if (vote_now) begin
                unique case (rx_state_reg)
                    RX_START: begin
                        if (maj) begin
                            rx_state_next = RX_IDLE;
                            armed_next = 1'b1;
                        end else begin
                            rx_state_next = RX_DATA;
                            bit_next = 4'h0;
                            par_next = 1'b0;
                        end
                    end
                    RX_DATA: begin
                        sh_next = {maj, sh_reg[7:1]};
                        par_next = par_reg ^ maj;
                        bit_next = bit_inc;
                        if (bit_inc == cfg.char_bits) begin
                            rx_state_next = cfg.parity_enable ?
                                            RX_PARITY : RX_STOP;
                        end
                    end
                    RX_PARITY: begin
                        par_next = par_reg ^ maj;
                        rx_state_next = RX_STOP;
                    end
                    RX_STOP: begin
                        // Back to idle at once, further stop bits unseen
                        rx_state_next = RX_IDLE;
                        armed_next = maj;
                        word_next.data = sh_reg >> (USAH_CHAR_MAX -
                                                    cfg.char_bits);
                        word_next.frame_error_flag = ~maj;
                        word_next.parity_error_flag = cfg.parity_enable &
                            (par_reg ^ cfg.parity_odd);
                        word_next.overflow_flag = full_reg & ~rx_read;
                        valid_next = 1'b1;
                        full_next = 1'b1;
                    end
                    default: begin
                        rx_state_next = rx_state_reg;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_state_reg <= RX_IDLE;
            cnt_reg <= USAH_SAMPLE_FIRST;
            bit_reg <= 4'h0;
            sh_reg <= 8'h00;
            par_reg <= 1'b0;
            armed_reg <= 1'b0;
            word_reg <= '0;
            valid_reg <= 1'b0;
            full_reg <= 1'b0;
        end else begin
            rx_state_reg <= rx_state_next;
            cnt_reg <= cnt_next;
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            par_reg <= par_next;
            armed_reg <= armed_next;
            word_reg <= word_next;
            valid_reg <= valid_next;
            full_reg <= full_next;
        end
    end

    assign txd = txd_reg;
    assign shift_clock_pin = sck_reg;
    assign shift_clock_oe = oe_reg;
    assign tx_busy = busy_reg;
    assign tx_done = done_reg;
    assign rx_valid = valid_reg;
    assign rx_full = full_reg;
    assign rx_word = word_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence spi_last_edge;
        spi_state_reg == SPI_SHIFT && samp_en_reg &&
        edge_reg == USAH_SPI_EDGE_LAST && cfg.spi_host;
    endsequence

    sequence spi_word_out;
        tx_done && rx_valid && !busy_reg;
    endsequence

    sck_toggle_a: assert property (
        spi_state_reg == SPI_SHIFT && samp_en_reg && cfg.spi_host
        |=> sck_reg != $past(sck_reg))
        else $error("shift clock did not toggle on divider tick");
    sck_idle_a: assert property (
        spi_state_reg == SPI_IDLE && $past(spi_state_reg == SPI_IDLE)
        |-> sck_reg == $past(cfg.pin_invert_enable))
        else $error("idle shift clock level wrong");
    spi_frame_end_a: assert property (
        spi_last_edge |=> spi_word_out)
        else $error("SPI frame did not end after sixteen edges");
    spi_flags_zero_a: assert property (
        $past(cfg.spi_host) |-> rx_word.frame_error_flag == 1'b0 &&
        rx_word.parity_error_flag == 1'b0 && rx_word.overflow_flag == 1'b0)
        else $error("error flag set in SPI host mode");
    clk_oe_a: assert property (
        ##1 shift_clock_oe == $past(cfg.spi_host))
        else $error("shift clock enable does not follow host mode");
    sample_range_a: assert property (
        cnt_reg >= USAH_SAMPLE_FIRST && cnt_reg <= USAH_OSR_NORMAL)
        else $error("sample counter out of range");
    start_reject_a: assert property (
        !cfg.spi_host && rx_state_reg == RX_START && vote_now && maj
        |=> rx_state_reg == RX_IDLE)
        else $error("noisy start bit not rejected");
    vote_window_a: assert property (
        rx_state_reg == RX_DATA && $past(rx_state_reg) == RX_START
        |-> $past(cnt_reg) == ($past(dbl) ? 5'h06 : 5'h0a))
        else $error("start accepted outside vote window");
    stop_error_a: assert property (
        !cfg.spi_host && rx_state_reg == RX_STOP && vote_now && !maj
        |=> rx_valid && rx_word.frame_error_flag && rx_state_reg == RX_IDLE)
        else $error("low stop bit did not flag frame error");

endmodule

// ---- usah_far_model.sv ----
// Purpose: Far-side model, an SPI client plus an async serial transmitter.
// Assumes: Bench loads the client byte before every SPI transfer.
// Notes: Async bit length is given per frame in core clocks.
`timescale 1ns/1ns
module usah_far_model (
    input wire logic core_clk, // Core clock, async timing
    input wire logic spi_host, // Picks which line drives rxd
    input wire logic inv, // Shift clock idle level
    input wire logic pha, // Clock phase
    input wire logic lsb_first, // Data order
    input wire logic sck, // Shift clock from host
    input wire logic mosi, // Host data out
    output logic rxd // Line into the host
);
    logic miso = 1'b1;
    logic aline = 1'b1;
    logic [7:0] tx_byte = 8'h00;
    logic [7:0] rx_byte = 8'h00;
    int n_bits = 0;
    assign rxd = spi_host ? miso : aline;
    function automatic logic pick(input logic [7:0] b, input int i);
        return lsb_first ? b[i] : b[7-i];
    endfunction
    task automatic load(input logic [7:0] b);
        tx_byte = b;
        n_bits = 0;
        if (!pha)
            miso = pick(b, 0);
    endtask
    // ------------------------------------------------------------
    // SPI client: sample edge is leading for phase 0, trailing else
    // ------------------------------------------------------------
    always @(sck) begin
        if (spi_host && ((sck != inv) ^ pha)) begin
            rx_byte = lsb_first ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
            n_bits++;
            // Released line shows the inverse, not the last bit
            if (n_bits == 8)
                miso = ~miso;
        end else if (spi_host && (pha || n_bits < 8)) begin
            miso = pick(tx_byte, n_bits);
        end
    end
    // ------------------------------------------------------------
    // Async transmitter, exact bit rate
    // ------------------------------------------------------------
    task automatic send(input logic [7:0] d, input int nb, input logic pe,
        input logic par, input logic stop, input int bclk, input int sclk);
        @(negedge core_clk);
        aline = 1'b0;
        repeat (bclk) @(negedge core_clk);
        for (int i = 0; i < nb; i++) begin
            aline = d[i];
            repeat (bclk) @(negedge core_clk);
        end
        if (pe) begin
            aline = par;
            repeat (bclk) @(negedge core_clk);
        end
        aline = stop;
        repeat (sclk) @(negedge core_clk);
        aline = 1'b1;
    endtask
    task automatic dip(input int n);
        aline = 1'b0;
        repeat (n) @(negedge core_clk);
        aline = 1'b1;
    endtask
endmodule

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the SPI host and async receiver.
// Assumes: baud_div of 4, so one sample period is five core clocks.
// Notes: Random bytes from a fixed seed; corner frames written by hand.
`timescale 1ns/1ns
module tb_top;
    import usah_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    usah_cfg_s cfg;
    logic [15:0] baud_div;
    logic rxd, tx_start, rx_read, txd, sck, sck_oe;
    logic [7:0] tx_data;
    logic tx_busy, tx_done, rx_valid, rx_full;
    usah_rx_s rx_word;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;
    int n_edges = 0;
    int seed = 32'hc7c03a29;
    usah_top usah_top_inst (.core_clk(core_clk), .rst(rst), .cfg(cfg),
        .baud_div(baud_div), .rxd(rxd), .tx_start(tx_start),
        .tx_data(tx_data), .rx_read(rx_read), .txd(txd),
        .shift_clock_pin(sck), .shift_clock_oe(sck_oe), .tx_busy(tx_busy),
        .tx_done(tx_done), .rx_valid(rx_valid), .rx_full(rx_full),
        .rx_word(rx_word));
    usah_far_model usah_far_model_inst (.core_clk(core_clk),
        .spi_host(cfg.spi_host), .inv(cfg.pin_invert_enable),
        .pha(cfg.spi_clock_phase), .lsb_first(cfg.data_order_select),
        .sck(sck), .mosi(txd), .rxd(rxd));
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    always @(sck) n_edges++;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
        input string what);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wait_rx(input int lim, output logic got,
        output usah_rx_s w, output int n);
        got = 1'b0;
        w = '0;
        n = 0;
        while (n < lim && !got) begin
            @(negedge core_clk);
            n++;
            got = (rx_valid === 1'b1);
            w = rx_word;
        end
    endtask
    task automatic ack();
        @(negedge core_clk);
        rx_read = 1'b1;
        @(negedge core_clk);
        rx_read = 1'b0;
    endtask
    // ------------------------------------------------------------
    // SPI host transfer, client byte checked both ways
    // ------------------------------------------------------------
    task automatic spi_xfer(input logic [2:0] k);
        logic [7:0] mo, mi;
        logic got;
        usah_rx_s w;
        int n;
        mo = 8'($random(seed));
        mi = 8'($random(seed));
        // Idle level moves with invert, so switch it with host mode off
        cfg.spi_host = 1'b0;
        {cfg.data_order_select, cfg.spi_clock_phase} = k[2:1];
        cfg.pin_invert_enable = k[0];
        cfg.receive_mode_select = {1'b0, k[0]};
        repeat (2) @(negedge core_clk);
        cfg.spi_host = 1'b1;
        repeat (3) @(negedge core_clk);
        chk(sck, k[0], "sck idle");
        chk(sck_oe, 1, "sck oe");
        chk(rx_word[2:0], 0, "held flags");
        usah_far_model_inst.load(mi);
        n_edges = 0;
        tx_start = 1'b1;
        tx_data = mo;
        @(negedge core_clk);
        tx_start = 1'b0;
        chk(tx_busy, 1, "busy");
        wait_rx(200, got, w, n);
        chk(tx_done, 1, "done");
        chk(16'(n >= 75 && n <= 87), 1, "duration");
        chk(w.data, mi, "miso");
        chk({w.frame_error_flag, w.parity_error_flag, w.overflow_flag},
            0, "flags");
        chk(usah_far_model_inst.rx_byte, mo, "mosi");
        chk(16'(n_edges), 16, "edges");
        chk(sck, k[0], "sck end");
    endtask
    // ------------------------------------------------------------
    // Async frame; bad parity and low stop on request
    // ------------------------------------------------------------
    task automatic arx(input logic dbl, input int nb, input logic pe,
        input logic bad, input logic stop);
        logic [7:0] d;
        logic got;
        usah_rx_s w;
        int n, bclk;
        d = 8'($random(seed) & ((1 << nb) - 1));
        bclk = (dbl ? 8 : 16) * 5;
        cfg.spi_host = 1'b0;
        cfg.receive_mode_select = {1'b0, dbl};
        cfg.char_bits = 4'(nb);
        cfg.parity_enable = pe;
        cfg.parity_odd = 1'($random(seed));
        repeat (8) @(negedge core_clk);
        fork
            usah_far_model_inst.send(d, nb, pe, ^d ^ cfg.parity_odd ^ bad,
                stop, bclk, bclk);
            wait_rx(1200, got, w, n);
        join
        chk(got, 1, "valid");
        chk(w.data, d, "data");
        chk(w.frame_error_flag, !stop, "frame_error_flag");
        chk(w.parity_error_flag, pe & bad, "perr");
        chk(w.overflow_flag, 0, "ovf");
        chk(rx_full, 1, "full");
        ack();
    endtask
    task automatic b2b(input logic dbl);
        logic [7:0] d0, d1;
        logic got;
        usah_rx_s w;
        int n, bclk;
        d0 = 8'($random(seed));
        d1 = 8'($random(seed));
        bclk = (dbl ? 8 : 16) * 5;
        cfg.receive_mode_select = {1'b0, dbl};
        cfg.char_bits = 4'h8;
        cfg.parity_enable = 1'b0;
        fork
            begin
                // Stop cut to just past its vote samples
                usah_far_model_inst.send(d0, 8, 0, 0, 1, bclk,
                    (dbl ? 7 : 11) * 5);
                usah_far_model_inst.send(d1, 8, 0, 0, 1, bclk, bclk);
            end
            begin
                wait_rx(1200, got, w, n);
                chk(w.data, d0, "first");
                wait_rx(1200, got, w, n);
                chk(got, 1, "second");
                chk(w.data, d1, "second data");
                chk(w.overflow_flag, 1, "overflow");
            end
        join
        ack();
    endtask
    initial begin
        cfg = '0;
        cfg.char_bits = 4'h8;
        baud_div = 16'h0004;
        tx_start = 1'b0;
        tx_data = 8'h00;
        rx_read = 1'b0;
        repeat (6) @(negedge core_clk);
        chk({txd, sck_oe, tx_busy, rx_valid, rx_full}, 16'h0010, "rst out");
        chk(rx_word, 0, "rst word");
        rst = 1'b0;
        // No reads between transfers: overflow must still read zero
        for (int k = 0; k < 8; k++)
            spi_xfer(3'(k));
        ack();
        for (int k = 0; k < 8; k++)
            arx(k[0], 5 + k % 4, k[1], 0, 1);
        arx(0, 8, 1, 1, 1);
        arx(1, 7, 1, 1, 1);
        arx(0, 8, 0, 0, 0);
        arx(1, 6, 1, 0, 0);
        for (int k = 0; k < 2; k++) begin
            cfg.receive_mode_select = 2'(k);
            usah_far_model_inst.dip(k ? 10 : 25);
            begin : glitch
                logic got;
                usah_rx_s w;
                int n;
                wait_rx(300, got, w, n);
                chk(got, 0, "glitch");
            end
            arx(k[0], 8, 0, 0, 1);
        end
        b2b(0);
        b2b(1);
        spi_xfer(3'h6);
        results();
    end
endmodule
